// *** verilog/rdm_pkg.sv ***
`default_nettype none
package rdm_pkg;
    localparam int ADDR_W = 13;
    localparam int BANKS = 4;
    // two 72-bit beats (64 data plus 8 check_bit_pins) per clock
    localparam int DATA_W = 144;
    localparam int MEM_IDX_W = 6;
    localparam int MEM_DEPTH = 64;
    localparam int COL_W = 11;
    localparam int AUTOCLOSE_FLAG_BIT = 10;
    localparam int COL_HI_BIT = 11;
    localparam int BURST_LEN_LSB = 0;
    localparam int READ_LATENCY_SETTING_LSB = 4;
    localparam logic [2:0] BURST_LEN_2 = 3'h1;
    localparam logic [2:0] BURST_LEN_4 = 3'h2;
    localparam logic [2:0] BURST_LEN_8 = 3'h3;
    localparam logic [2:0] LATENCY_CODE_2 = 3'h2;
    localparam logic [2:0] LATENCY_CODE_2_5 = 3'h6;
    localparam logic [COL_W-1:0] COL_STEP = 11'h002;
    // module latency = component latency + 1 register stage
    localparam logic [1:0] READ_LATENCY = 2'h3;
    localparam logic [1:0] READ_LOAD = READ_LATENCY - 2'h1;
    localparam logic [1:0] FLOAT_DELAY = 2'h3;
    localparam logic [1:0] FLOAT_LOAD = FLOAT_DELAY - 2'h1;
    localparam logic [1:0] WRITE_DATA_LAG = 2'h2;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
        CMD_STOP, CMD_PRE, CMD_REF, CMD_MODE
    } rdm_cmd_t;

    typedef enum logic [1:0] {ST_IDLE, ST_PWRDN, ST_SELFREF} rdm_mode_t;

    typedef struct packed {
        rdm_mode_t mode;
        logic [BANKS-1:0] bankOpen;
        logic [BANKS-1:0][ADDR_W-1:0] rowAddr;
        logic [2:0] blCode;
        logic halfShift;
        logic [1:0] rdPend;
        logic [2:0] rdLeft;
        logic [1:0] rdBank;
        logic [COL_W-1:0] rdCol;
        logic rdAuto;
        logic [1:0] stopCnt;
        logic wrPend;
        logic [2:0] wrLeft;
        logic [1:0] wrBank;
        logic [COL_W-1:0] wrCol;
        logic wrAuto;
        logic dqOe;
        logic [DATA_W-1:0] dqOut;
    } rdm_main_t;

    localparam rdm_main_t MAIN_RESET = '{
        mode: ST_IDLE, blCode: BURST_LEN_4, default: '0};

    typedef struct packed {
        logic valid;
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic cke;
        logic [ADDR_W-1:0] addr;
        logic [1:0] bank;
    } rdm_reg_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } rdm_sync_t;

    function automatic rdm_cmd_t rdm_decode(input logic csN,
        input logic rasN, input logic casN, input logic weN);
        rdm_cmd_t c;
        c = CMD_NOP;
        if (!csN) begin
            case ({rasN, casN, weN})
                3'h0: c = CMD_MODE;
                3'h1: c = CMD_REF;
                3'h2: c = CMD_PRE;
                3'h3: c = CMD_ACT;
                3'h4: c = CMD_WRITE;
                3'h5: c = CMD_READ;
                3'h6: c = CMD_STOP;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : rdm_decode

    function automatic logic [2:0] rdm_pairs(input logic [2:0] blCode);
        case (blCode)
            BURST_LEN_2: return 3'h1;
            BURST_LEN_8: return 3'h4;
            default: return 3'h2;
        endcase
    endfunction : rdm_pairs

    function automatic logic [MEM_IDX_W-1:0] rdm_mem_idx(
        input logic [1:0] bank, input logic [COL_W-1:0] col);
        return {bank, col[4:1]};
    endfunction : rdm_mem_idx
endpackage : rdm_pkg
`default_nettype wire

// *** verilog/rdm_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module rdm_sync
    import rdm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic asyncIn,
    output logic syncOut
);
    rdm_sync_t st;
    rdm_sync_t next_st;

    always_comb begin
        next_st.stage1 = asyncIn;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.stage2;
endmodule : rdm_sync
`default_nettype wire

// *** verilog/rdm_cmd_reg.sv ***
`timescale 1ns/1ns
`default_nettype none
module rdm_cmd_reg
    import rdm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clearN,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic cke,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0] bankSel,
    output logic regValid,
    output logic regCsN,
    output logic regRasN,
    output logic regCasN,
    output logic regWeN,
    output logic regCke,
    output logic [ADDR_W-1:0] regAddr,
    output logic [1:0] regBank
);
    rdm_reg_t st;
    rdm_reg_t next_st;

    always_comb begin
        next_st = '0;
        if (clearN) begin
            next_st = '{valid: 1'b1, csN: csN, rasN: rasN, casN: casN,
                weN: weN, cke: cke, addr: addr, bank: bankSel};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign regValid = st.valid;
    assign regCsN = st.csN;
    assign regRasN = st.rasN;
    assign regCasN = st.casN;
    assign regWeN = st.weN;
    assign regCke = st.cke;
    assign regAddr = st.addr;
    assign regBank = st.bank;

    a_reset_low: assert property (@(posedge clk_sys) disable iff (rst)
        !clearN |=> (st == '0))
        else $error("register outputs not low during module reset");
endmodule : rdm_cmd_reg
`default_nettype wire

// *** verilog/rdm_module_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - outputs float three cycles after burst stop
// - outputs float three cycles after precharge of the read bank or all banks
// - write data captured two cycles after command
// - power down entry takes one cycle
// - deselect ignores inputs, bursts continue
// - row from activate, column on read/write
// - precharge closes all or selected bank
// - autoclose flag closes bank after burst
// - two select inputs decode four banks
// - clock enable low enters power down/self refresh
// - module reset clears input registers, outputs low
// - read latency is component latency plus one
module rdm_module_top
    import rdm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic resetN,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0] arrayGroupSel,
    input wire logic cke,
    input wire logic [DATA_W-1:0] dqPairIn,
    output logic [DATA_W-1:0] dqPairOut,
    output logic dqOe,
    output logic dqsOe,
    output logic halfShift,
    output logic [1:0] modeState,
    output logic [BANKS-1:0] bankOpen
);
    logic syncResetN;
    logic regValid;
    logic regCsN;
    logic regRasN;
    logic regCasN;
    logic regWeN;
    logic regCke;
    logic [ADDR_W-1:0] regAddr;
    logic [1:0] regBank;
    rdm_cmd_t cmd;
    rdm_main_t st;
    rdm_main_t next_st;
    logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
    logic memWe;
    logic [MEM_IDX_W-1:0] memIdx;
    logic [DATA_W-1:0] memWdata;
    logic readBusy;
    logic cmdLive;
    logic [2:0] pairs;
    logic [COL_W-1:0] cmdCol;

    rdm_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncIn(resetN),
        .syncOut(syncResetN)
    );

    // input register stage of the module
    rdm_cmd_reg u_cmd (
        .clk_sys(clk_sys),
        .rst(rst),
        .clearN(syncResetN),
        .csN(csN),
        .rasN(rasN),
        .casN(casN),
        .weN(weN),
        .cke(cke),
        .addr(addr),
        .bankSel(arrayGroupSel),
        .regValid(regValid),
        .regCsN(regCsN),
        .regRasN(regRasN),
        .regCasN(regCasN),
        .regWeN(regWeN),
        .regCke(regCke),
        .regAddr(regAddr),
        .regBank(regBank)
    );

    assign cmd = rdm_decode(regCsN, regRasN, regCasN, regWeN);
    assign pairs = rdm_pairs(st.blCode);
    assign cmdCol = {regAddr[COL_HI_BIT], regAddr[9:0]};
    assign cmdLive = (st.mode == ST_IDLE) && regCke && regValid;

    always_comb begin
        next_st = st;
        memWe = 1'b0;
        memIdx = rdm_mem_idx(st.wrBank, st.wrCol);
        memWdata = dqPairIn;
        readBusy = (st.rdPend != 2'h0) || st.dqOe;
        // read data pipeline, bursts run on under deselect
        if (st.rdPend != 2'h0) begin
            next_st.rdPend = st.rdPend - 2'h1;
            if (st.rdPend == 2'h1) begin
                next_st.dqOe = 1'b1;
                next_st.dqOut = mem[rdm_mem_idx(st.rdBank, st.rdCol)];
                next_st.rdLeft = pairs - 3'h1;
                next_st.rdCol = st.rdCol + COL_STEP;
            end
        end else if (st.dqOe) begin
            if (st.rdLeft != 3'h0) begin
                next_st.dqOut = mem[rdm_mem_idx(st.rdBank, st.rdCol)];
                next_st.rdLeft = st.rdLeft - 3'h1;
                next_st.rdCol = st.rdCol + COL_STEP;
            end else begin
                next_st.dqOe = 1'b0;
                if (st.rdAuto) begin
                    next_st.bankOpen[st.rdBank] = 1'b0;
                end
            end
        end
        // write data capture
        if (st.wrPend || (st.wrLeft != 3'h0)) begin
            memWe = 1'b1;
            next_st.wrPend = 1'b0;
            next_st.wrCol = st.wrCol + COL_STEP;
            next_st.wrLeft = st.wrPend ? pairs - 3'h1 : st.wrLeft - 3'h1;
            if ((next_st.wrLeft == 3'h0) && st.wrAuto) begin
                next_st.bankOpen[st.wrBank] = 1'b0;
            end
        end
        // forced float after stop or precharge
        if (st.stopCnt != 2'h0) begin
            next_st.stopCnt = st.stopCnt - 2'h1;
            if (st.stopCnt == 2'h1) begin
                next_st.dqOe = 1'b0;
                next_st.rdPend = 2'h0;
                next_st.rdLeft = 3'h0;
            end
        end
        case (st.mode)
            ST_IDLE: begin
                if (!regCke) begin
                    if (cmd == CMD_REF) begin
                        next_st.mode = ST_SELFREF;
                    end else begin
                        next_st.mode = ST_PWRDN;
                    end
                end else begin
                    case (cmd)
                        CMD_ACT: begin
                            next_st.bankOpen[regBank] = 1'b1;
                            next_st.rowAddr[regBank] = regAddr;
                        end
                        CMD_READ: begin
                            next_st.rdPend = READ_LOAD;
                            next_st.rdBank = regBank;
                            next_st.rdCol = cmdCol;
                            next_st.rdAuto = regAddr[AUTOCLOSE_FLAG_BIT];
                            next_st.rdLeft = 3'h0;
                            next_st.stopCnt = 2'h0;
                        end
                        CMD_WRITE: begin
                            next_st.wrPend = 1'b1;
                            next_st.wrLeft = 3'h0;
                            next_st.wrBank = regBank;
                            next_st.wrCol = cmdCol;
                            next_st.wrAuto = regAddr[AUTOCLOSE_FLAG_BIT];
                        end
                        CMD_STOP: begin
                            if (readBusy) begin
                                next_st.stopCnt = FLOAT_LOAD;
                            end
                        end
                        CMD_PRE: begin
                            if (regAddr[AUTOCLOSE_FLAG_BIT]) begin
                                next_st.bankOpen = '0;
                            end else begin
                                next_st.bankOpen[regBank] = 1'b0;
                            end
                            if (readBusy && (regAddr[AUTOCLOSE_FLAG_BIT]
                                || (regBank == st.rdBank))) begin
                                next_st.stopCnt = FLOAT_LOAD;
                            end
                        end
                        CMD_MODE: begin
                            if (regBank == 2'h0) begin
                                case (regAddr[BURST_LEN_LSB +: 3])
                                    BURST_LEN_2, BURST_LEN_4, BURST_LEN_8:
                                        next_st.blCode =
                                            regAddr[BURST_LEN_LSB +: 3];
                                    default: ;
                                endcase
                                case (regAddr[READ_LATENCY_SETTING_LSB +: 3])
                                    LATENCY_CODE_2: next_st.halfShift = 1'b0;
                                    LATENCY_CODE_2_5:
                                        next_st.halfShift = 1'b1;
                                    default: ;
                                endcase
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_PWRDN, ST_SELFREF: begin
                if (regCke) begin
                    next_st.mode = ST_IDLE;
                end
            end
            default: next_st.mode = ST_IDLE;
        endcase
        if (!regValid) begin
            next_st = MAIN_RESET;
            memWe = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= MAIN_RESET;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (memWe) begin
            mem[memIdx] <= memWdata;
        end
    end

    assign dqPairOut = st.dqOut;
    assign dqOe = st.dqOe;
    assign dqsOe = st.dqOe;
    assign halfShift = st.halfShift;
    assign modeState = st.mode;
    assign bankOpen = st.bankOpen;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_read_latency: assert property (
        cmdLive && cmd == CMD_READ ##1 (regValid && cmd == CMD_NOP)[*2]
        |-> ##1 st.dqOe)
        else $error("read data not driven three cycles after read");

    a_stop_float: assert property (
        cmdLive && cmd == CMD_STOP && readBusy
        ##1 (regValid && cmd == CMD_NOP)[*2] |-> ##1 !st.dqOe)
        else $error("outputs not floated after burst stop");

    a_pre_float: assert property (
        cmdLive && cmd == CMD_PRE && readBusy && (regAddr[AUTOCLOSE_FLAG_BIT]
        || regBank == st.rdBank) ##1 (regValid && cmd == CMD_NOP)[*2]
        |-> ##1 !st.dqOe)
        else $error("outputs not floated after precharge");

    a_write_lag: assert property (
        cmdLive && cmd == CMD_WRITE |=> memWe && memIdx ==
        rdm_mem_idx($past(regBank), {$past(regAddr[COL_HI_BIT]),
        $past(regAddr[9:0])}))
        else $error("write data not captured two cycles after write");

    a_row_capture: assert property (
        cmdLive && cmd == CMD_ACT
        |=> st.rowAddr[$past(regBank)] == $past(regAddr))
        else $error("row address not taken on activate");

    a_bank_decode: assert property (
        cmdLive && cmd == CMD_ACT |=> st.bankOpen[$past(regBank)])
        else $error("selected bank not opened");

    a_pre_all: assert property (
        cmdLive && cmd == CMD_PRE && regAddr[AUTOCLOSE_FLAG_BIT]
        |=> st.bankOpen == '0)
        else $error("precharge all left a bank open");

    a_autoclose_take: assert property (
        cmdLive && cmd == CMD_READ
        |=> st.rdAuto == $past(regAddr[AUTOCLOSE_FLAG_BIT]))
        else $error("autoclose flag not taken on read");

    a_desel_hold: assert property (
        regValid && regCsN |=> st.rowAddr == $past(st.rowAddr)
        && st.blCode == $past(st.blCode))
        else $error("deselected command changed state");

    a_pd_entry: assert property (
        regValid && st.mode == ST_IDLE && !regCke && cmd != CMD_REF
        |=> st.mode == ST_PWRDN)
        else $error("power down not entered in one cycle");

    a_lowpower_exit: assert property (
        regValid && st.mode != ST_IDLE && regCke |=> st.mode == ST_IDLE)
        else $error("low power state not left on clock enable high");

    c_read: cover property (cmdLive && cmd == CMD_READ ##3 st.dqOe);
    c_write: cover property (cmdLive && cmd == CMD_WRITE ##1 memWe);
    c_stop: cover property (cmdLive && cmd == CMD_STOP && st.dqOe);
    c_selfref: cover property (st.mode == ST_SELFREF);
endmodule : rdm_module_top
`default_nettype wire

// *** test/rdm_ctrl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rdm_ctrl_model
    import rdm_pkg::*;
(
    input wire logic clk_sys,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic cke,
    output logic [ADDR_W-1:0] addr,
    output logic [1:0] arrayGroupSel,
    output logic [DATA_W-1:0] dqPairIn
);
    // {rasN, casN, weN} in command enum order
    localparam logic [2:0] PIN_CODE [8] = '{3'h7, 3'h3, 3'h5, 3'h4,
        3'h6, 3'h2, 3'h1, 3'h0};
    localparam int REF_DUE = 700;
    int cyc = 0;
    int half = 2;
    int slow = 0;
    int wrAt [BANKS] = '{default: -99};
    int rdAt [BANKS] = '{default: -99};
    int stopAt = -99;
    int modeAt = -99;
    int srOut = -999;
    int pdOut = -99;
    int refAt = 0;
    logic inSr = 1'b0;
    logic [BANKS-1:0] rowOpen = '0;

    initial begin
        {csN, rasN, casN, weN, cke} = 5'h1F;
        addr = '0;
        arrayGroupSel = '0;
        dqPairIn = '0;
    end

    always @(posedge clk_sys) cyc <= cyc + 1;

    function automatic int mx(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : mx

    // pins held one edge, then deselect with flipped address
    task automatic drive(input rdm_cmd_t c, input logic [1:0] b,
        input logic [ADDR_W-1:0] a, input logic desel);
        csN = desel;
        {rasN, casN, weN} = PIN_CODE[c];
        addr = a;
        arrayGroupSel = b;
        @(negedge clk_sys);
        {csN, rasN, casN, weN} = 4'hF;
        addr = ~a;
        arrayGroupSel = ~b;
    endtask : drive

    task automatic issue(input rdm_cmd_t c, input logic [1:0] b,
        input logic [ADDR_W-1:0] a, input logic desel);
        int due;
        if (!desel && rowOpen == '0 && cyc - refAt > REF_DUE) begin
            drive(CMD_REF, 2'h0, '0, 1'b0);
            refAt = cyc;
        end
        due = mx(pdOut + 1, srOut + ((c == CMD_READ) ? 200 : 12));
        for (int i = 0; i < BANKS; i++) begin
            if (c == CMD_PRE && (a[AUTOCLOSE_FLAG_BIT] || i == b)) begin
                due = mx(due, mx(wrAt[i] + 4 + half, rdAt[i] + half));
            end
            if (c == CMD_READ) due = mx(due, wrAt[i] + 2 + half);
            if (c == CMD_WRITE) due = mx(due, rdAt[i] + 2 + slow + half);
        end
        if (c == CMD_WRITE) due = mx(due, stopAt + 2 + slow);
        if (c == CMD_ACT || c == CMD_MODE) due = mx(due, modeAt + 2);
        if (c == CMD_ACT) due = mx(due, refAt + 8);
        for (int i = 0; i < 5000 && cyc + 1 < due; i++) @(negedge clk_sys);
        drive(c, b, a, desel);
        if (desel) return;
        if (c == CMD_ACT) rowOpen[b] = 1'b1;
        if (c == CMD_PRE && a[AUTOCLOSE_FLAG_BIT]) rowOpen = '0;
        if (c == CMD_PRE && !a[AUTOCLOSE_FLAG_BIT]) rowOpen[b] = 1'b0;
        if ((c == CMD_READ || c == CMD_WRITE) && a[AUTOCLOSE_FLAG_BIT])
            rowOpen[b] = 1'b0;
        if (c == CMD_READ) rdAt[b] = cyc;
        if (c == CMD_WRITE) wrAt[b] = cyc;
        if (c == CMD_STOP) stopAt = cyc;
        if (c == CMD_MODE) begin
            modeAt = cyc;
            half = (a[2:0] == BURST_LEN_8) ? 4 : 2;
            slow = (a[6:4] == LATENCY_CODE_2_5) ? 1 : 0;
        end
    endtask : issue

    task automatic setCke(input logic v, input rdm_cmd_t c);
        cke = v;
        drive(c, 2'h0, '0, c == CMD_NOP);
        if (c == CMD_REF) refAt = cyc;
        if (v) pdOut = cyc;
        if (v && inSr) srOut = cyc;
        inSr = !v && c == CMD_REF;
    endtask : setCke

    // first pair sampled two edges after the write
    task automatic wrBurst(input logic [DATA_W-1:0] d, input int n);
        @(negedge clk_sys);
        for (int i = 0; i < n; i++) begin
            dqPairIn = d + DATA_W'(i);
            @(negedge clk_sys);
        end
        dqPairIn = ~dqPairIn;
    endtask : wrBurst
endmodule : rdm_ctrl_model
`default_nettype wire

// *** test/tb_registered_ddr_module_command_timing.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_registered_ddr_module_command_timing
    import rdm_pkg::*;
;
    typedef struct packed {
        rdm_cmd_t c;
        logic [1:0] b;
        logic [ADDR_W-1:0] a;
        logic d;
        logic [BANKS-1:0] open;
    } rdm_row_t;
    localparam logic [DATA_W-1:0] D0 = {9{16'hC3A5}};
    localparam logic [DATA_W-1:0] D1 = {9{16'h5A3C}};
    localparam logic [DATA_W-1:0] D2 = {9{16'h0F1E}};
    localparam rdm_row_t ROWS [7] = '{
        '{CMD_ACT, 2'h0, 13'h1FFF, 1'b0, 4'h1},
        '{CMD_ACT, 2'h1, 13'h0000, 1'b0, 4'h3},
        '{CMD_ACT, 2'h2, 13'h0ABC, 1'b1, 4'h3},
        '{CMD_ACT, 2'h2, 13'h0ABC, 1'b0, 4'h7},
        '{CMD_ACT, 2'h3, 13'h1555, 1'b0, 4'hF},
        '{CMD_PRE, 2'h2, 13'h1BFF, 1'b0, 4'hB},
        '{CMD_PRE, 2'h1, 13'h0400, 1'b0, 4'h0}};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic resetN = 1'b1;
    wire logic csN, rasN, casN, weN, cke, dqOe, dqsOe, halfShift;
    wire logic [ADDR_W-1:0] addr;
    wire logic [1:0] arrayGroupSel;
    wire logic [1:0] modeState;
    wire logic [BANKS-1:0] bankOpen;
    wire logic [DATA_W-1:0] dqPairIn;
    wire logic [DATA_W-1:0] dqPairOut;
    int err_total = 0;
    int checks_done = 0;

    rdm_module_top dut_u (.clk_sys(clk_sys), .rst(rst), .resetN(resetN),
        .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .addr(addr),
        .arrayGroupSel(arrayGroupSel), .cke(cke), .dqPairIn(dqPairIn),
        .dqPairOut(dqPairOut), .dqOe(dqOe), .dqsOe(dqsOe),
        .halfShift(halfShift), .modeState(modeState), .bankOpen(bankOpen));
    rdm_ctrl_model host_u (.clk_sys(clk_sys), .csN(csN), .rasN(rasN),
        .casN(casN), .weN(weN), .cke(cke), .addr(addr),
        .arrayGroupSel(arrayGroupSel), .dqPairIn(dqPairIn));

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // lead edges after the command, then n pairs, then float
    task automatic rdCheck(input int lead, input int n,
        input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] e;
        repeat (lead - 1) @(negedge clk_sys);
        chk(dqOe === 1'b0, "drive too early");
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            e = d + DATA_W'(i);
            chk({dqOe, dqsOe} === 2'h3 && dqPairOut === e, "pair");
        end
        @(negedge clk_sys);
        chk(dqOe === 1'b0, "float after burst");
    endtask : rdCheck

    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        $display("mismatch at %0t: run did not finish", $time);
        summarize();
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        chk(bankOpen === '0 && dqOe === 1'b0, "reset state");
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        foreach (ROWS[i]) begin
            host_u.issue(ROWS[i].c, ROWS[i].b, ROWS[i].a, ROWS[i].d);
            repeat (2) @(negedge clk_sys);
            chk(bankOpen === ROWS[i].open, "bank flags");
        end
        host_u.issue(CMD_MODE, 2'h0, 13'h0063, 1'b0);
        @(negedge clk_sys);
        chk(halfShift === 1'b1, "latency flag");
        host_u.issue(CMD_ACT, 2'h1, 13'h0123, 1'b0);
        host_u.issue(CMD_WRITE, 2'h1, 13'h0000, 1'b0);
        host_u.wrBurst(D2, 4);
        host_u.issue(CMD_READ, 2'h1, 13'h0000, 1'b0);
        rdCheck(3, 4, D2);
        host_u.issue(CMD_MODE, 2'h0, 13'h0022, 1'b0);
        @(negedge clk_sys);
        chk(halfShift === 1'b0, "latency flag");
        host_u.issue(CMD_WRITE, 2'h1, 13'h0004, 1'b0);
        host_u.wrBurst(D0, 2);
        host_u.issue(CMD_READ, 2'h1, 13'h0004, 1'b0);
        rdCheck(3, 2, D0);
        chk(bankOpen === 4'h2, "open after plain read");
        host_u.issue(CMD_READ, 2'h1, 13'h0004, 1'b0);
        host_u.issue(CMD_STOP, 2'h0, 13'h0000, 1'b0);
        rdCheck(2, 1, D0);
        host_u.issue(CMD_READ, 2'h1, 13'h0004, 1'b0);
        host_u.issue(CMD_STOP, 2'h0, 13'h0000, 1'b1);
        rdCheck(2, 2, D0);
        host_u.issue(CMD_ACT, 2'h3, 13'h0001, 1'b0);
        host_u.issue(CMD_READ, 2'h1, 13'h0404, 1'b0);
        rdCheck(3, 2, D0);
        repeat (2) @(negedge clk_sys);
        chk(bankOpen === 4'h8, "closed after read");
        host_u.issue(CMD_ACT, 2'h1, 13'h0002, 1'b0);
        host_u.issue(CMD_WRITE, 2'h1, 13'h0408, 1'b0);
        host_u.wrBurst(D1, 2);
        repeat (2) @(negedge clk_sys);
        chk(bankOpen === 4'h8, "closed after write");
        host_u.issue(CMD_ACT, 2'h1, 13'h0002, 1'b0);
        host_u.issue(CMD_READ, 2'h1, 13'h0008, 1'b0);
        host_u.issue(CMD_PRE, 2'h1, 13'h0000, 1'b0);
        rdCheck(1, 2, D1);
        chk(bankOpen === 4'h8, "precharge one bank");
        host_u.setCke(1'b0, CMD_NOP);
        chk(modeState === 2'h0, "entry too early");
        @(negedge clk_sys);
        chk(modeState === 2'h1, "power down");
        host_u.setCke(1'b1, CMD_NOP);
        @(negedge clk_sys);
        chk(modeState === 2'h0, "power down exit");
        host_u.issue(CMD_PRE, 2'h0, 13'h0400, 1'b0);
        host_u.setCke(1'b0, CMD_REF);
        @(negedge clk_sys);
        chk(modeState === 2'h2, "self refresh");
        host_u.setCke(1'b1, CMD_NOP);
        @(negedge clk_sys);
        chk(modeState === 2'h0, "self refresh exit");
        host_u.issue(CMD_ACT, 2'h1, 13'h0000, 1'b0);
        host_u.issue(CMD_READ, 2'h1, 13'h0000, 1'b0);
        rdCheck(3, 2, D2);
        host_u.issue(CMD_MODE, 2'h0, 13'h0062, 1'b0);
        resetN = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(bankOpen === '0 && halfShift === 1'b0, "module reset");
        chk(dqOe === 1'b0 && dqPairOut === '0, "module reset");
        resetN = 1'b1;
        summarize();
    end
endmodule : tb_registered_ddr_module_command_timing
`default_nettype wire
